// ---- core/isra_defs.svh ----
`ifndef ISRA_DEFS_SVH
`define ISRA_DEFS_SVH

// ----------------------------------------
// Register byte offsets, lower byte shown
// ----------------------------------------
`define ISRA_OFF_FLASH_WRITE_COUNT     7'h00
`define ISRA_OFF_SUPPLY_VOLTAGE_OUTPUT 7'h02
`define ISRA_OFF_ACCEL_X_OUTPUT        7'h04
`define ISRA_OFF_ACCEL_Y_OUTPUT        7'h06
`define ISRA_OFF_ACCEL_Z_OUTPUT        7'h08
`define ISRA_OFF_AUX_CONVERTER_OUTPUT  7'h0A
`define ISRA_OFF_TEMPERATURE_OUTPUT    7'h0C
`define ISRA_OFF_PEAK_X_OUTPUT         7'h0E
`define ISRA_OFF_PEAK_Y_OUTPUT         7'h10
`define ISRA_OFF_PEAK_Z_OUTPUT         7'h12
`define ISRA_OFF_PEAK_SUM_SQUARES      7'h14
`define ISRA_OFF_CAPTURE_SAMPLE_XY     7'h16
`define ISRA_OFF_CAPTURE_SAMPLE_Z      7'h18
`define ISRA_OFF_ERROR_FLAGS           7'h1A
`define ISRA_OFF_EVENT_COUNTER         7'h1C
`define ISRA_OFF_FIRMWARE_CHECKSUM     7'h1E
`define ISRA_OFF_OFFSET_ADJUST_X       7'h20
`define ISRA_OFF_OFFSET_ADJUST_Y       7'h22
`define ISRA_OFF_OFFSET_ADJUST_Z       7'h24
`define ISRA_OFF_CLOCK_HOUR_MINUTE     7'h2E
`define ISRA_OFF_CLOCK_MONTH_DAY       7'h30
`define ISRA_OFF_CLOCK_YEAR_VALUE      7'h32
`define ISRA_OFF_WAKEUP_HOUR_MINUTE    7'h34
`define ISRA_OFF_WAKEUP_MONTH_DAY      7'h36
`define ISRA_OFF_ALARM_ONE_THRESHOLD   7'h38
`define ISRA_OFF_ALARM_TWO_THRESHOLD   7'h3A
`define ISRA_OFF_ALARM_CONTROL         7'h3C
`define ISRA_OFF_EXT_TRIGGER_CONTROL   7'h3E
`define ISRA_OFF_CAPTURE_ADDR_POINTER  7'h40
`define ISRA_OFF_CAPTURE_CONFIG        7'h42
`define ISRA_OFF_DIGITAL_IO_CONTROL    7'h44
`define ISRA_OFF_MISC_CONTROL          7'h46
`define ISRA_OFF_SAMPLE_PERIOD_CONTROL 7'h48
`define ISRA_OFF_SYSTEM_COMMAND        7'h4A

// ----------------------------------------
// Register file shape and reset values
// ----------------------------------------
`define ISRA_RO_LAST_WORD  4'hF
`define ISRA_CFG_NUM       17
`define ISRA_CFG_NONE      5'h1F
`define ISRA_CFG_IDX_GPIO  5'h0E
`define ISRA_CFG_IDX_MISC  5'h0F
`define ISRA_RST_ZERO      16'h0000
`define ISRA_RST_ALARM     16'h9000
`define ISRA_RST_CAPTURE   16'h0022
`define ISRA_RST_MISC      16'h0006
`define ISRA_RST_SAMPLE    16'h001F

// ----------------------------------------
// Frame and field positions
// ----------------------------------------
`define ISRA_FRM_LAST_BIT  4'hF
`define ISRA_FRM_WR_BIT    15
`define ISRA_CMD_FLASH_BIT 3
`define ISRA_CMD_WAKE_BIT  8
`define ISRA_MSC_DRDY_EN   2
`define ISRA_MSC_DRDY_POL  1

// ----------------------------------------
// Timing
// ----------------------------------------
`define ISRA_CLK_HZ        50000000
`define ISRA_SCLK_MAX_HZ   2500000
`define ISRA_HALF_CYC      ((`ISRA_CLK_HZ + 2 * `ISRA_SCLK_MAX_HZ - 1) / (2 * `ISRA_SCLK_MAX_HZ))
`define ISRA_CS_LEAD_CYC   4
`define ISRA_CS_GAP_CYC    8
`define ISRA_DRDY_CYC      4

// ----------------------------------------
// Host command port
// ----------------------------------------
`define ISRA_HREG_TX       2'h0
`define ISRA_HREG_STAT     2'h1
`define ISRA_HREG_RX       2'h2

`endif

// ---- core/isra_pkg.sv ----
package isra_pkg;
    typedef logic [15:0] isra_word_t;
    typedef enum logic {DEV_BOOT, DEV_RUN} isra_dev_st_t;
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} isra_host_st_t;
endpackage

// ---- core/isra_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface isra_link_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso;
    logic multifunction_pin_one_out;
    logic multifunction_pin_one_oe;
    logic multifunction_pin_one_level;

    // Undriven pin reads low
    assign multifunction_pin_one_level = multifunction_pin_one_oe ? multifunction_pin_one_out : 1'b0;

    modport dev  (input sclk, input cs_b, input mosi, output miso, output multifunction_pin_one_out, output multifunction_pin_one_oe);
    modport host (output sclk, output cs_b, output mosi, input miso, input multifunction_pin_one_level);
endinterface
`default_nettype wire

// ---- core/isra_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module isra_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule
`default_nettype wire

// ---- core/isra_dev.sv ----
// What this block does
// - Runs alone after reset, refreshing output registers
// - Default setup drives data-ready on pin one
// - Slave only, full-duplex receive and transmit
// - Master uses mode 3, MSB first, 2.5MHz
// - Write frame changes one byte only
// - Frame 0xCB01 sets wake bit eight
// - Master writes both bytes as two frames
// - Read is command frame then data frame
// - Upper or lower address returns whole register
// - Each frame shifts previous frame's answer out, zero after a write
// - Even address lower byte, odd upper byte
// - Reserved addresses unused, no function
// - Flash save only on both-byte command bit three
// - Capture sample registers never saved to flash
// - IO and misc control boot to defaults
// - Registers take documented reset defaults
// - Command write-only, outputs read-only, config read-write
// - Chip select low; sample rising, drive falling
// - Boot copies flash into working registers first
`timescale 1ns/10ps
`default_nettype none
`include "isra_defs.svh"
module isra_dev (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_por_b,
    isra_link_if.dev                   link,
    input  wire logic                  i_sample_strobe,
    input  wire isra_pkg::isra_word_t  i_ro_data [1:15],
    output var  isra_pkg::isra_word_t  o_cfg [0:`ISRA_CFG_NUM-1],
    output logic                       o_wake,
    output logic                       o_flash_save,
    output logic                       o_cmd_strobe,
    output logic [15:0]                o_cmd_word,
    output logic                       o_boot_done
);
    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    function automatic logic [4:0] cfg_idx(input logic [6:0] addr);
        logic [6:0] off;
        off = {addr[6:1], 1'b0};
        case (off)
            `ISRA_OFF_OFFSET_ADJUST_X:       cfg_idx = 5'h00;
            `ISRA_OFF_OFFSET_ADJUST_Y:       cfg_idx = 5'h01;
            `ISRA_OFF_OFFSET_ADJUST_Z:       cfg_idx = 5'h02;
            `ISRA_OFF_CLOCK_HOUR_MINUTE:     cfg_idx = 5'h03;
            `ISRA_OFF_CLOCK_MONTH_DAY:       cfg_idx = 5'h04;
            `ISRA_OFF_CLOCK_YEAR_VALUE:      cfg_idx = 5'h05;
            `ISRA_OFF_WAKEUP_HOUR_MINUTE:    cfg_idx = 5'h06;
            `ISRA_OFF_WAKEUP_MONTH_DAY:      cfg_idx = 5'h07;
            `ISRA_OFF_ALARM_ONE_THRESHOLD:   cfg_idx = 5'h08;
            `ISRA_OFF_ALARM_TWO_THRESHOLD:   cfg_idx = 5'h09;
            `ISRA_OFF_ALARM_CONTROL:         cfg_idx = 5'h0A;
            `ISRA_OFF_EXT_TRIGGER_CONTROL:   cfg_idx = 5'h0B;
            `ISRA_OFF_CAPTURE_ADDR_POINTER:  cfg_idx = 5'h0C;
            `ISRA_OFF_CAPTURE_CONFIG:        cfg_idx = 5'h0D;
            `ISRA_OFF_DIGITAL_IO_CONTROL:    cfg_idx = `ISRA_CFG_IDX_GPIO;
            `ISRA_OFF_MISC_CONTROL:          cfg_idx = `ISRA_CFG_IDX_MISC;
            `ISRA_OFF_SAMPLE_PERIOD_CONTROL: cfg_idx = 5'h10;
            default:                         cfg_idx = `ISRA_CFG_NONE;
        endcase
    endfunction

    function automatic isra_pkg::isra_word_t cfg_default(input logic [4:0] idx);
        case (idx)
            5'h08, 5'h09:       cfg_default = `ISRA_RST_ALARM;
            5'h0D:              cfg_default = `ISRA_RST_CAPTURE;
            `ISRA_CFG_IDX_MISC: cfg_default = `ISRA_RST_MISC;
            5'h10:              cfg_default = `ISRA_RST_SAMPLE;
            default:            cfg_default = `ISRA_RST_ZERO;
        endcase
    endfunction

    function automatic logic cfg_flashed(input logic [4:0] idx);
        cfg_flashed = (idx != `ISRA_CFG_IDX_GPIO) && (idx != `ISRA_CFG_IDX_MISC);
    endfunction

    // ----------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       cs_act;
    logic       mosi_s;
    logic       sclk_d_q;
    logic       rise;
    logic       fall;

    isra_sync #(.W(3), .RST(3'b110)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_d       ({link.sclk, link.cs_b, link.mosi}),
        .o_q       (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_act = ~pins_s[1];
    assign mosi_s = pins_s[0];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    assign rise = cs_act & sclk_s & ~sclk_d_q;
    assign fall = cs_act & ~sclk_s & sclk_d_q;

    // ----------------------------------------
    // Boot sequencing
    // ----------------------------------------
    isra_pkg::isra_dev_st_t st_q;
    logic                   boot_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q   <= isra_pkg::DEV_BOOT;
            boot_q <= 1'b0;
        end else begin
            case (st_q)
                isra_pkg::DEV_BOOT: st_q <= isra_pkg::DEV_RUN;
                isra_pkg::DEV_RUN:  st_q <= isra_pkg::DEV_RUN;
                default:            st_q <= isra_pkg::DEV_BOOT;
            endcase
            boot_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Receive shift and frame decode
    // ----------------------------------------
    logic [3:0]  bit_cnt_q;
    logic [15:0] rx_q;
    logic [15:0] frm_word;
    logic        frame_end;
    logic        wr_frame;
    logic [6:0]  frm_addr;
    logic [7:0]  frm_data;
    logic [4:0]  frm_idx;
    logic        wr_cfg;
    logic        wr_cmd;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_cnt_q <= 4'h0;
            rx_q      <= 16'h0000;
        end else if (!cs_act) begin
            bit_cnt_q <= 4'h0; // Aborted frame restarts cleanly
        end else if (rise) begin
            rx_q      <= frm_word;
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    assign frm_word  = {rx_q[14:0], mosi_s};
    assign frame_end = rise && (bit_cnt_q == `ISRA_FRM_LAST_BIT) && (st_q == isra_pkg::DEV_RUN);
    assign wr_frame  = frm_word[`ISRA_FRM_WR_BIT];
    assign frm_addr  = frm_word[14:8];
    assign frm_data  = frm_word[7:0];
    assign frm_idx   = cfg_idx(frm_addr);
    assign wr_cfg    = frame_end && wr_frame && (frm_idx != `ISRA_CFG_NONE);
    assign wr_cmd    = frame_end && wr_frame && ({frm_addr[6:1], 1'b0} == `ISRA_OFF_SYSTEM_COMMAND);

    // ----------------------------------------
    // Working, output and flash registers
    // ----------------------------------------
    isra_pkg::isra_word_t cfg_q   [0:`ISRA_CFG_NUM-1];
    isra_pkg::isra_word_t flash_q [0:`ISRA_CFG_NUM-1];
    isra_pkg::isra_word_t ro_q    [1:15];
    logic [15:0]          flash_write_count_q;
    logic                 save_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < `ISRA_CFG_NUM; i++) begin
                cfg_q[i] <= cfg_default(5'(i));
            end
        end else if (st_q == isra_pkg::DEV_BOOT) begin
            for (int i = 0; i < `ISRA_CFG_NUM; i++) begin
                if (cfg_flashed(5'(i))) begin
                    cfg_q[i] <= flash_q[i];
                end
            end
        end else if (wr_cfg) begin
            if (frm_addr[0]) begin
                cfg_q[frm_idx][15:8] <= frm_data;
            end else begin
                cfg_q[frm_idx][7:0] <= frm_data;
            end
        end
    end

    // Flash image survives the functional reset, only power-on resets it to defaults
    always_ff @(posedge i_ref_clk or negedge i_por_b) begin
        if (!i_por_b) begin
            for (int i = 0; i < `ISRA_CFG_NUM; i++) begin
                flash_q[i] <= cfg_default(5'(i));
            end
            flash_write_count_q <= 16'h0000;
        end else if (save_q) begin
            for (int i = 0; i < `ISRA_CFG_NUM; i++) begin
                if (cfg_flashed(5'(i))) begin
                    flash_q[i] <= cfg_q[i];
                end
            end
            flash_write_count_q <= flash_write_count_q + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 1; i < 16; i++) begin
                ro_q[i] <= 16'h0000;
            end
        end else if (i_sample_strobe && (st_q == isra_pkg::DEV_RUN)) begin
            for (int i = 1; i < 16; i++) begin
                ro_q[i] <= i_ro_data[i];
            end
        end
    end

    // ----------------------------------------
    // System command
    // ----------------------------------------
    logic [15:0] cmd_q;
    logic [15:0] cmd_full;
    logic        cmd_lo_q;
    logic        cmd_hi_q;
    logic        cmd_both;
    logic        wake_q;
    logic        strobe_q;

    assign cmd_full = frm_addr[0] ? {frm_data, cmd_q[7:0]} : {cmd_q[15:8], frm_data};
    assign cmd_both = wr_cmd && (frm_addr[0] ? cmd_lo_q : cmd_hi_q);

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_q    <= 16'h0000;
            cmd_lo_q <= 1'b0;
            cmd_hi_q <= 1'b0;
            wake_q   <= 1'b0;
            save_q   <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            wake_q   <= wr_cmd && frm_addr[0] && frm_data[`ISRA_CMD_WAKE_BIT - 8];
            save_q   <= cmd_both && cmd_full[`ISRA_CMD_FLASH_BIT];
            strobe_q <= cmd_both;
            if (wr_cmd) begin
                cmd_q    <= cmd_full;
                cmd_lo_q <= ~cmd_both & (cmd_lo_q | ~frm_addr[0]);
                cmd_hi_q <= ~cmd_both & (cmd_hi_q | frm_addr[0]);
            end
        end
    end

    // ----------------------------------------
    // Read answer and transmit shift
    // ----------------------------------------
    logic [15:0] rd_data;
    logic [15:0] resp_q;
    logic [15:0] tx_q;
    logic        miso_q;
    logic [3:0]  rd_word;

    assign rd_word = frm_addr[4:1];

    always_comb begin
        rd_data = 16'h0000;
        if (frm_addr[6:5] == 2'b00) begin
            rd_data = (rd_word == 4'h0) ? flash_write_count_q : ro_q[rd_word];
        end else if (frm_idx != `ISRA_CFG_NONE) begin
            rd_data = cfg_q[frm_idx];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            resp_q <= 16'h0000;
            tx_q   <= 16'h0000;
            miso_q <= 1'b0;
        end else begin
            if (frame_end) begin
                resp_q <= wr_frame ? 16'h0000 : rd_data;
                tx_q   <= wr_frame ? 16'h0000 : rd_data;
            end else if (!cs_act) begin
                tx_q <= resp_q;
            end else if (fall) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
            if (fall) begin
                miso_q <= tx_q[15];
            end
        end
    end

    // ----------------------------------------
    // Data-ready on the first multifunction pin
    // ----------------------------------------
    logic [7:0] drdy_cnt_q;
    logic       multifunction_pin_one_out_q;
    logic       multifunction_pin_one_oe_q;
    logic       drdy_act;

    assign drdy_act = (drdy_cnt_q != 8'h00);

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drdy_cnt_q <= 8'h00;
            multifunction_pin_one_out_q <= 1'b0;
            multifunction_pin_one_oe_q  <= 1'b0;
        end else begin
            if (i_sample_strobe && (st_q == isra_pkg::DEV_RUN)) begin
                drdy_cnt_q <= 8'(`ISRA_DRDY_CYC);
            end else if (drdy_act) begin
                drdy_cnt_q <= drdy_cnt_q - 8'h01;
            end
            multifunction_pin_one_oe_q  <= cfg_q[`ISRA_CFG_IDX_MISC][`ISRA_MSC_DRDY_EN];
            multifunction_pin_one_out_q <= drdy_act ~^ cfg_q[`ISRA_CFG_IDX_MISC][`ISRA_MSC_DRDY_POL];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.miso     = miso_q;
    assign link.multifunction_pin_one_out = multifunction_pin_one_out_q;
    assign link.multifunction_pin_one_oe  = multifunction_pin_one_oe_q;
    assign o_cfg         = cfg_q;
    assign o_wake        = wake_q;
    assign o_flash_save  = save_q;
    assign o_cmd_strobe  = strobe_q;
    assign o_cmd_word    = cmd_q;
    assign o_boot_done   = boot_q;
endmodule
`default_nettype wire

// ---- core/isra_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "isra_defs.svh"
module isra_host (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    isra_link_if.host        link,
    input  wire logic [1:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [15:0]      o_rdata
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] pins_s;

    isra_sync #(.W(2), .RST(2'b00)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_d       ({link.miso, link.multifunction_pin_one_level}),
        .o_q       (pins_s)
    );

    // ----------------------------------------
    // Frame engine, mode 3, MSB first
    // ----------------------------------------
    isra_pkg::isra_host_st_t st_q;
    logic [7:0]  div_q;
    logic [3:0]  bit_q;
    logic [15:0] tx_q;
    logic [15:0] sh_q;
    logic [15:0] rx_q;
    logic [15:0] last_rx_q;
    logic        sclk_q;
    logic        cs_b_q;
    logic        mosi_q;
    logic        tick;
    logic        start;

    assign tick  = (div_q == 8'h00);
    assign start = i_wr && (i_addr == `ISRA_HREG_TX) && (st_q == isra_pkg::H_IDLE); // Busy writes dropped

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q      <= isra_pkg::H_IDLE;
            div_q     <= 8'h00;
            bit_q     <= 4'h0;
            tx_q      <= 16'h0000;
            sh_q      <= 16'h0000;
            rx_q      <= 16'h0000;
            last_rx_q <= 16'h0000;
            sclk_q    <= 1'b1;
            cs_b_q    <= 1'b1;
            mosi_q    <= 1'b0;
        end else begin
            if (!tick) begin
                div_q <= div_q - 8'h01;
            end
            case (st_q)
                isra_pkg::H_IDLE: begin
                    if (start) begin
                        tx_q   <= i_wdata;
                        sh_q   <= i_wdata;
                        bit_q  <= 4'h0;
                        cs_b_q <= 1'b0;
                        div_q  <= 8'(`ISRA_CS_LEAD_CYC - 1);
                        st_q   <= isra_pkg::H_LEAD;
                    end
                end
                isra_pkg::H_LEAD, isra_pkg::H_HIGH: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        mosi_q <= sh_q[15];
                        div_q  <= 8'(`ISRA_HALF_CYC - 1);
                        st_q   <= isra_pkg::H_LOW;
                    end
                end
                isra_pkg::H_LOW: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        rx_q   <= {rx_q[14:0], pins_s[1]};
                        sh_q   <= {sh_q[14:0], 1'b0};
                        bit_q  <= bit_q + 4'h1;
                        div_q  <= 8'(`ISRA_HALF_CYC - 1);
                        st_q   <= (bit_q == `ISRA_FRM_LAST_BIT) ? isra_pkg::H_TAIL : isra_pkg::H_HIGH;
                    end
                end
                isra_pkg::H_TAIL: begin
                    if (tick) begin
                        cs_b_q    <= 1'b1;
                        last_rx_q <= rx_q;
                        div_q     <= 8'(`ISRA_CS_GAP_CYC - 1);
                        st_q      <= isra_pkg::H_GAP;
                    end
                end
                isra_pkg::H_GAP: begin
                    if (tick) begin
                        st_q <= isra_pkg::H_IDLE;
                    end
                end
                default: st_q <= isra_pkg::H_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Command port read-back
    // ----------------------------------------
    logic [15:0] rdata_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `ISRA_HREG_TX:   rdata_q <= tx_q;
                `ISRA_HREG_STAT: rdata_q <= {14'h0, pins_s[0], (st_q != isra_pkg::H_IDLE)};
                `ISRA_HREG_RX:   rdata_q <= last_rx_q;
                default:         rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata   = rdata_q;
    assign link.sclk = sclk_q;
    assign link.cs_b = cs_b_q;
    assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// ---- testbench/isra_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module isra_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso,
    input wire logic multifunction_pin_one_level
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------
    // Link timing, frame length and ready pulse
    // ----------
    logic [4:0] falls_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) falls_q <= 5'h00;
        else if (cs_b) falls_q <= 5'h00;
        else if ($fell(sclk)) falls_q <= falls_q + 5'h01;
    end
    property p_idle; cs_b |-> sclk; endproperty
    a_idle: assert property (p_idle) else $error("clock not idle high");
    property p_lead; $fell(cs_b) |-> sclk[*4]; endproperty
    a_lead: assert property (p_lead) else $error("select lead short");
    property p_low; $fell(sclk) |-> (!sclk)[*8]; endproperty
    a_low: assert property (p_low) else $error("clock low too short");
    property p_high; $rose(sclk) |-> sclk[*8]; endproperty
    a_high: assert property (p_high) else $error("clock high too short");
    property p_len; $rose(cs_b) |-> falls_q == 5'h10; endproperty
    a_len: assert property (p_len) else $error("frame not 16 bits");
    property p_miso; !cs_b && $changed(miso) |-> !sclk; endproperty
    a_miso: assert property (p_miso) else $error("miso moved with clock high");
    property p_mosi; !cs_b && $changed(mosi) |-> !sclk; endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved with clock high");
    property p_rdy; $rose(multifunction_pin_one_level) |-> multifunction_pin_one_level[*4] ##1 !multifunction_pin_one_level; endproperty
    a_rdy: assert property (p_rdy) else $error("ready pulse length");
endmodule
`default_nettype wire

// ---- testbench/impact_sensor_spi_register_access_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module impact_sensor_spi_register_access_tb_top;
    logic                 i_ref_clk = 1'b0, i_rst_b = 1'b0, stb = 1'b0, wr = 1'b0, rd = 1'b0, wake;
    logic                 por_b = 1'b0, save, cstb, boot;
    logic [1:0]           ad = 2'h0;
    logic [15:0]          wd = 16'h0000, rdat, w, x, cw = 16'h0000, cmdw;
    logic [15:0]          cmds [19] = '{16'h0300, 16'h0200, 16'h0400, 16'h3900, 16'h4200, 16'h4600, 16'h4800,
                                        16'hA1AB, 16'hA05C, 16'h2000, 16'h8455, 16'h0400, 16'hCB01, 16'h4A00,
                                        16'hCA08, 16'h0100, 16'hC600, 16'h4600, 16'h0000};
    isra_pkg::isra_word_t ro [1:15] = '{default: 16'h0000};
    int                   n_errors = 0, num_checks = 0, seed = 32'h04B8, nwake = 0, nsave = 0, nstb = 0, mdl [0:63];
    int                   cb = 0, ncmd = 0;
    isra_link_if link ();
    isra_dev isra_dev_inst (.i_ref_clk, .i_rst_b, .i_por_b(por_b), .link(link), .i_sample_strobe(stb),
        .i_ro_data(ro), .o_cfg(), .o_wake(wake), .o_flash_save(save), .o_cmd_strobe(cstb), .o_cmd_word(cmdw),
        .o_boot_done(boot));
    isra_host isra_host_inst (.i_ref_clk, .i_rst_b, .link(link), .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdat));
    isra_asserts isra_asserts_inst (.i_ref_clk, .i_rst_b, .sclk(link.sclk), .cs_b(link.cs_b), .mosi(link.mosi),
        .miso(link.miso), .multifunction_pin_one_level(link.multifunction_pin_one_level));
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        if (wake === 1'b1) nwake++;
        if (save === 1'b1) nsave++;
        if (cstb === 1'b1) nstb++;
    end
    // Words that hold a value; the rest read back as zero
    function automatic bit is_kept(input int i);
        return i < 19 || (i > 22 && i < 37);
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input logic [1:0] a, input logic wv, input logic [15:0] d);
        @(posedge i_ref_clk);
        ad <= a; wr <= wv; rd <= !wv; wd <= d;
        @(posedge i_ref_clk);
        wr <= 1'b0; rd <= 1'b0;
        #1;
    endtask
    task automatic frame(input logic [15:0] f);
        int k;
        int i;
        i = f[14:9];
        cyc(2'h0, 1'b1, f);
        for (k = 0; k < 999; k++) begin
            cyc(2'h1, 1'b0, 16'h0000);
            if (k > 2 && rdat[0] === 1'b0) break;
        end
        if (k == 999) begin
            n_errors++;
            complete_run();
        end
        cyc(2'h2, 1'b0, 16'h0000);
        chk("rx word", x, rdat);
        x = (!f[15] && is_kept(i)) ? mdl[i][15:0] : 16'h0000;
        if (f[15] && i > 15 && is_kept(i) && f[8]) mdl[i][15:8] = f[7:0];
        if (f[15] && i > 15 && is_kept(i) && !f[8]) mdl[i][7:0] = f[7:0];
        // Command acts once both bytes are in, in either order
        if (f[15] && i == 37) begin
            cb = cb | (f[8] ? 2 : 1);
            if (f[8]) cw[15:8] = f[7:0];
            else cw[7:0] = f[7:0];
            if (cb == 3) begin
                cb = 0;
                ncmd++;
                if (cw[3]) mdl[0]++;
            end
        end
    endtask
    // -------------
    // Main sequence
    // -------------
    initial begin
        mdl[28] = 16'h9000; mdl[29] = 16'h9000; mdl[33] = 16'h0022; mdl[35] = 16'h0006; mdl[36] = 16'h001F;
        x = 16'h0000;
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        por_b <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        for (int i = 1; i < 16; i++) begin
            w = 16'($random(seed));
            ro[i] <= w;
            mdl[i] = w;
        end
        stb <= 1'b1;
        @(posedge i_ref_clk);
        stb <= 1'b0;
        foreach (cmds[j]) frame(cmds[j]);
        chk("command word", cw, cmdw);
        // Functional reset only: flash image and its count survive
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        for (int i = 1; i < 16; i++) mdl[i] = 0;
        mdl[35] = 16'h0006;
        x = 16'h0000;
        cb = 0;
        frame(16'h2000);
        frame(16'h4600);
        // Random writes kept below offset 0x40, clear of misc control, so ready stays enabled
        for (int j = 0; j < 12; j++) begin
            w = 16'($random(seed));
            if (w[15]) w[14] = 1'b0;
            frame(w);
        end
        frame(16'h0000);
        chk("wake count", 16'h0001, nwake[15:0]);
        chk("save count", mdl[0][15:0], nsave[15:0]);
        chk("command count", ncmd[15:0], nstb[15:0]);
        chk("boot done", 16'h0001, {15'h0, boot});
        complete_run();
    end
endmodule
`default_nettype wire
